// [bench/iod_decoder_tb.sv]
// Self-checking testbench of the instruction operand decoder.
`timescale 1ns/1ps
module iod_decoder_tb;
  logic              core_clk;
  logic              rst;
  logic              word_valid;
  logic [15:0]       fetch_word;
  logic              word_ready;
  logic [20:0]       next_pc;
  logic [11:0]       src_base;
  logic [11:0]       dst_base;
  logic              discard_next;
  logic              tp_load;
  logic [20:0]       tp_load_val;
  logic              dec_valid;
  iod_pkg::iod_dec_s dec;
  logic [20:0]       table_pointer;
  int                n_errors = 0;
  int                n_checks = 0;

  iod_decoder dut (.core_clk(core_clk), .rst(rst), .word_valid(word_valid), .fetch_word(fetch_word),
    .word_ready(word_ready), .next_pc(next_pc), .src_base(src_base), .dst_base(dst_base),
    .discard_next(discard_next), .tp_load(tp_load), .tp_load_val(tp_load_val),
    .dec_valid(dec_valid), .dec(dec), .table_pointer(table_pointer));

  iod_prog_mem mem (.core_clk(core_clk), .word_ready(word_ready), .word_valid(word_valid),
    .fetch_word(fetch_word));

  // The clock runs at 50 MHz.
  always #10 core_clk = ~core_clk;

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  task automatic report_and_stop();
    if (n_errors == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : report_and_stop

  // Hand over one word and look at the answer in the cycle that it stands.
  task automatic take(input logic [15:0] w, input logic exp_v, input int gap);
    mem.send(w, gap);
    #1;
    chk(dec_valid, exp_v);
  endtask : take

  // A word after a change of flow must come back as a no-operation.
  task automatic flush_chk();
    take(16'h2401, 1'b1, 0);
    chk(dec.kind, iod_pkg::IOD_K_NOP);
  endtask : flush_chk

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_byte();
    for (int i = 0; i < 4; i++)
    begin
      take({6'b001001, i[1], i[0], 8'hA5}, 1'b1, i);
      chk(dec.kind, iod_pkg::IOD_K_BYTE);
      chk(dec.dest_to_file, i[1]);
      chk(dec.use_bank, i[0]);
      chk(dec.file_addr[7:0], 8'hA5);
    end
  endtask : t_byte

  task automatic t_bit();
    for (int b = 0; b < 8; b++)
    begin
      take({4'b1000, b[2:0], b[0], 8'h3C}, 1'b1, 0);
      chk(dec.kind, iod_pkg::IOD_K_BIT);
      chk(dec.bit_sel, b[2:0]);
      chk(dec.use_bank, b[0]);
      chk(dec.file_addr[7:0], 8'h3C);
    end
    take(16'h0E5A, 1'b1, 0);
    chk(dec.kind, iod_pkg::IOD_K_LIT);
    chk(dec.literal, 8'h5A);
  endtask : t_bit

  task automatic t_move();
    take(16'hC123, 1'b0, 0);
    take(16'hF456, 1'b1, 0);
    chk(dec.kind, iod_pkg::IOD_K_MOVE);
    chk({dec.src_addr, dec.dst_addr}, 24'h123456);
    take(16'hF456, 1'b1, 0);
    chk(dec.kind, iod_pkg::IOD_K_NOP);
    take(16'hC123, 1'b0, 0);
    take(16'h2401, 1'b1, 0);
    chk(dec.kind, iod_pkg::IOD_K_NOP);
    take(16'hEE25, 1'b0, 0);
    take(16'hF0A7, 1'b1, 0);
    chk(dec.kind, iod_pkg::IOD_K_LFSR);
    chk({dec.file_addr, dec.literal}, 20'h002A7);
  endtask : t_move

  // Jump, then call without and with the fast bit.
  task automatic t_jump();
    for (int i = 0; i < 3; i++)
    begin
      take((i == 0) ? 16'hEF12 : {7'b1110110, i[1], 8'h12}, 1'b0, 0);
      take(16'hF345, 1'b1, 0);
      chk(dec.kind, (i == 0) ? iod_pkg::IOD_K_JUMP : iod_pkg::IOD_K_CALL);
      chk(dec.target, 21'h068A24);
      if (i > 0)
        chk(dec.fast, i[1]);
      flush_chk();
    end
  endtask : t_jump

  task automatic br(input logic [15:0] w, input iod_pkg::iod_kind_e k, input logic [20:0] tgt);
    take(w, 1'b1, 0);
    chk(dec.kind, k);
    chk(dec.target, tgt);
  endtask : br

  // Next address is 0x100; displacements at both ends of each field.
  task automatic t_branch();
    br(16'hD7FF, iod_pkg::IOD_K_REL_JMP, 21'h0000FE);
    flush_chk();
    br(16'hD3FF, iod_pkg::IOD_K_REL_JMP, 21'h0008FE);
    flush_chk();
    br(16'hDC00, iod_pkg::IOD_K_RCALL, 21'h1FF900);
    flush_chk();
    br(16'hE280, iod_pkg::IOD_K_BCOND, 21'h000000);
    br(16'hE27F, iod_pkg::IOD_K_BCOND, 21'h0001FE);
  endtask : t_branch

  // Every read and write mode from a pointer at its top value, so increments wrap.
  task automatic t_table();
    logic [1:0] m;
    for (int i = 0; i < 8; i++)
    begin
      m = i[1:0];
      @(posedge core_clk);
      tp_load <= 1'b1;
      @(posedge core_clk);
      tp_load <= 1'b0;
      take(16'h0008 + i[15:0], 1'b1, 0);
      chk(dec.kind, iod_pkg::IOD_K_TBL);
      chk({dec.tbl_write, dec.tbl_mode}, i[2:0]);
      chk(dec.tbl_addr, (m == 2'h3) ? 21'h000000 : 21'h1FFFFF);
      chk(table_pointer, (m == 2'h0) ? 21'h1FFFFF : (m == 2'h2) ? 21'h1FFFFE : 21'h000000);
    end
  endtask : t_table

  // Indexed move with the unused bits of the second word both clear and set.
  task automatic t_idx();
    for (int i = 0; i < 2; i++)
    begin
      take(16'hEBFF, 1'b0, 0);
      take(i ? 16'hFFD5 : 16'hF055, 1'b1, 0);
      chk(dec.kind, iod_pkg::IOD_K_IDX_MOVE);
      chk({dec.src_addr, dec.dst_addr}, 24'h17F255);
    end
  endtask : t_idx

  task automatic t_ret();
    for (int s = 0; s < 2; s++)
    begin
      take(16'h0012 | s[15:0], 1'b1, 0);
      chk(dec.kind, iod_pkg::IOD_K_RET);
      chk(dec.fast, s[0]);
      flush_chk();
    end
    @(posedge core_clk);
    discard_next <= 1'b1;
    @(posedge core_clk);
    discard_next <= 1'b0;
    take(16'h0E5A, 1'b1, 0);
    chk(dec.kind, iod_pkg::IOD_K_NOP);
  endtask : t_ret

  // ----------------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------------
  initial
  begin
    core_clk = 1'b0;
    rst = 1'b1;
    discard_next = 1'b0;
    tp_load = 1'b0;
    tp_load_val = 21'h1FFFFF;
    next_pc = 21'h000100;
    src_base = 12'h100;
    dst_base = 12'h200;
    repeat (11) @(posedge core_clk);
    #1;
    chk({word_ready, dec_valid, |dec}, 3'h0);
    chk(table_pointer, 21'h000000);
    @(posedge core_clk);
    rst <= 1'b0;
    t_byte();
    t_bit();
    t_move();
    t_jump();
    t_branch();
    t_table();
    t_idx();
    t_ret();
    report_and_stop();
  end

  // The run needs about 230 cycles; a hang is cut off well beyond that.
  initial
  begin
    #200000;
    n_errors++;
    report_and_stop();
  end
endmodule : iod_decoder_tb

// [bench/iod_prog_mem.sv]
// Program memory model that offers instruction words to the decoder.
`timescale 1ns/1ps
module iod_prog_mem (
  // Clock
  input  wire logic        core_clk,
  // Word handshake
  input  wire logic        word_ready,
  output logic             word_valid,
  output logic [15:0]      fetch_word
);
  logic rdy_s;

  // Ready is caught before each rising edge, so a take is judged without a race.
  always @(negedge core_clk) rdy_s <= word_ready;

  // The bus starts idle.
  initial
  begin
    word_valid = 1'b0;
    fetch_word = 16'h0000;
  end

  // Offer one word after gap + 1 idle cycles and hold it until the edge that takes it.
  task automatic send(input logic [15:0] w, input int gap);
    repeat (gap + 1) @(posedge core_clk);
    fetch_word <= w;
    word_valid <= 1'b1;
    do @(posedge core_clk); while (rdy_s !== 1'b1);
    word_valid <= 1'b0;
    // A released bus shows the inverse, so a stale word is never mistaken for data.
    fetch_word <= ~w;
  endtask : send
endmodule : iod_prog_mem

// [hw/iod_decoder.sv]
// Operand decoder for 16-bit instruction words of an 8-bit core.
`timescale 1ns/1ps
`include "iod_map.svh"

// Summary of operation
// RULE1 - Table ops pick keep, post-increment, post-decrement or pre-increment pointer.
// RULE2 - Table pointer is 21 bits and addresses program memory.
// RULE3 - Relative branch operand is signed; call, jump, return operands are direct.
// RULE4 - Fast bit 0 leaves shadows alone; 1 saves or restores shadow copies.
// RULE5 - Indexed addressing uses separate 7-bit source and destination offsets.
// RULE6 - Don't-care bits decode the same whether 0 or 1.
// RULE7 - Destination bit 0 writes working register, 1 writes file register.
// RULE8 - Access bit 0 forces access bank, 1 uses bank select register.
// RULE9 - Byte and bit file ops carry an 8-bit file address.
// RULE10 - File-to-file move: 12-bit source first word, 12-bit destination second.
// RULE11 - Bit ops carry a 3-bit bit number.
// RULE12 - Literal ops carry an 8-bit immediate in the low byte.
// RULE13 - Jump and call target: bits 7:0 first word, 19:8 second word.
// RULE14 - Unconditional relative branch uses signed bits 10 down to 0.
// RULE15 - Conditional relative branches use signed bits 7 down to 0.
// RULE16 - A lone second word executes as a no-operation.
// RULE17 - Instruction cycle is four clocks; a PC change adds a no-operation cycle.
// RULE18 - Relative target is next address plus displacement times two.
// RULE19 - Indexed offsets add unsigned to the pointer base.
module iod_decoder (
  // Clock and reset
  input  wire logic            core_clk,
  input  wire logic            rst,
  // Program memory words
  input  wire logic            word_valid,
  input  wire logic [15:0]     fetch_word,
  output logic                 word_ready,
  // Core context
  input  wire logic [20:0]     next_pc,
  input  wire logic [11:0]     src_base,
  input  wire logic [11:0]     dst_base,
  input  wire logic            discard_next,
  input  wire logic            tp_load,
  input  wire logic [20:0]     tp_load_val,
  // Decoded result
  output logic                 dec_valid,
  output iod_pkg::iod_dec_s    dec,
  output logic [20:0]          table_pointer
);

  // ----------------------------------------------------------------------
  // Classification helpers
  // ----------------------------------------------------------------------

  // Casez wildcards make every don't-care bit decode identically.
  function automatic iod_pkg::iod_kind_e iod_classify(input logic [15:0] w);
    iod_pkg::iod_kind_e k;
    k = iod_pkg::IOD_K_OTHER;
    casez (w) // see RULE6
      16'b0000_0000_0000_1???: k = iod_pkg::IOD_K_TBL;
      16'b0000_0000_0001_00??: k = iod_pkg::IOD_K_RET;
      16'b0000_0000_????_????: k = iod_pkg::IOD_K_OTHER;
      16'b0000_0001_????_????: k = iod_pkg::IOD_K_LIT;
      16'b0000_1???_????_????: k = iod_pkg::IOD_K_LIT;
      16'b0111_????_????_????: k = iod_pkg::IOD_K_BIT;
      16'b0???_????_????_????: k = iod_pkg::IOD_K_BYTE;
      16'b10??_????_????_????: k = iod_pkg::IOD_K_BIT;
      16'b1100_????_????_????: k = iod_pkg::IOD_K_MOVE;
      16'b1101_0???_????_????: k = iod_pkg::IOD_K_REL_JMP;
      16'b1101_1???_????_????: k = iod_pkg::IOD_K_RCALL;
      16'b1110_0???_????_????: k = iod_pkg::IOD_K_BCOND;
      16'b1110_1011_1???_????: k = iod_pkg::IOD_K_IDX_MOVE;
      16'b1110_110?_????_????: k = iod_pkg::IOD_K_CALL;
      16'b1110_1110_????_????: k = iod_pkg::IOD_K_LFSR;
      16'b1110_1111_????_????: k = iod_pkg::IOD_K_JUMP;
      16'b1111_????_????_????: k = iod_pkg::IOD_K_NOP; // see RULE16
      default:                 k = iod_pkg::IOD_K_OTHER;
    endcase
    return k;
  endfunction : iod_classify

  // Signed word displacement turned into a byte offset.
  function automatic logic [20:0] iod_rel(input logic [20:0] base, input logic [10:0] disp);
    logic [20:0] ext;
    ext = {{10{disp[10]}}, disp};
    return base + {ext[19:0], 1'b0}; // see RULE18
  endfunction : iod_rel

  // ----------------------------------------------------------------------
  // Instruction cycle phase
  // ----------------------------------------------------------------------
  logic [1:0]           q_reg;
  iod_pkg::iod_state_e  state_reg;
  logic [15:0]          first_reg;
  logic                 flush_reg;
  logic [20:0]          tp_reg;
  logic                 take;
  logic                 take1;
  iod_pkg::iod_kind_e   kind_now;
  iod_pkg::iod_kind_e   kind_first;
  iod_pkg::iod_dec_s    dec_next;
  logic                 two_word;
  logic                 second_ok;

  // A word is taken once per four clocks, at the last phase.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      q_reg <= 2'h0;
    else
      q_reg <= q_reg + 2'h1; // see RULE17
  end

  assign word_ready = (q_reg == `IOD_Q_LAST);
  assign take       = word_ready && word_valid;
  assign take1      = take && (state_reg == iod_pkg::IOD_S_FIRST) && !flush_reg;
  assign kind_now   = iod_classify(fetch_word);
  assign kind_first = iod_classify(first_reg);
  assign two_word   = (kind_now == iod_pkg::IOD_K_MOVE) || (kind_now == iod_pkg::IOD_K_CALL) ||
                      (kind_now == iod_pkg::IOD_K_JUMP) || (kind_now == iod_pkg::IOD_K_LFSR) ||
                      (kind_now == iod_pkg::IOD_K_IDX_MOVE);
  assign second_ok  = (fetch_word[15:12] == `IOD_SECOND_TAG);

  // ----------------------------------------------------------------------
  // Two-word sequencing
  // ----------------------------------------------------------------------

  // The first word is held until its companion arrives in the next cycle.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= iod_pkg::IOD_S_FIRST;
      first_reg <= 16'h0000;
    end
    else if (take)
    begin
      if (take1 && two_word)
      begin
        state_reg <= iod_pkg::IOD_S_SECOND;
        first_reg <= fetch_word;
      end
      else
        state_reg <= iod_pkg::IOD_S_FIRST;
    end
  end

  // A PC change, or a skip reported by the core, turns the next word into a NOP.
  // The core request wins over the clear, but a skip pending when a second word is taken leaves that word decoded as usual.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      flush_reg <= 1'b0;
    else if (discard_next)
      flush_reg <= 1'b1;
    else if (take && (state_reg == iod_pkg::IOD_S_FIRST))
      flush_reg <= take1 && (kind_now inside {iod_pkg::IOD_K_REL_JMP, iod_pkg::IOD_K_RCALL,
                                              iod_pkg::IOD_K_RET}); // see RULE17
    else if (take)
      flush_reg <= (kind_first inside {iod_pkg::IOD_K_JUMP, iod_pkg::IOD_K_CALL});
  end

  // ----------------------------------------------------------------------
  // Operand extraction
  // ----------------------------------------------------------------------
  always_comb
  begin
    dec_next              = '0;
    dec_next.kind         = iod_pkg::IOD_K_NOP;
    dec_next.tbl_addr     = tp_reg;
    if (state_reg == iod_pkg::IOD_S_FIRST)
    begin
      if (!flush_reg)
        dec_next.kind = kind_now;
      dec_next.dest_to_file = fetch_word[`IOD_DEST_BIT];  // see RULE7
      dec_next.use_bank     = fetch_word[`IOD_BANK_BIT];  // see RULE8
      dec_next.file_addr    = {4'h0, fetch_word[7:0]};    // see RULE9
      dec_next.bit_sel      = fetch_word[11:9];           // see RULE11
      dec_next.literal      = fetch_word[7:0];            // see RULE12
      dec_next.fast         = fetch_word[`IOD_FAST_BIT];  // see RULE4
      dec_next.tbl_write    = fetch_word[`IOD_TBL_WR_BIT];
      dec_next.tbl_mode     = fetch_word[1:0];            // see RULE1
      if (fetch_word[1:0] == `IOD_TBL_PRE_INC)
        dec_next.tbl_addr = tp_reg + 21'h000001;
      // Relative forms are signed, the rest direct.
      if (kind_now == iod_pkg::IOD_K_BCOND)
        dec_next.target = iod_rel(next_pc, {{3{fetch_word[7]}}, fetch_word[7:0]}); // see RULE15, RULE3
      else
        dec_next.target = iod_rel(next_pc, fetch_word[10:0]); // see RULE14, RULE3
    end
    else if (second_ok)
    begin
      dec_next.kind     = kind_first;
      dec_next.src_addr = first_reg[11:0];  // see RULE10
      dec_next.dst_addr = fetch_word[11:0]; // see RULE10
      dec_next.target   = {fetch_word[11:0], first_reg[7:0], 1'b0}; // see RULE13, RULE3
      dec_next.fast     = first_reg[`IOD_CALL_FAST_BIT];            // see RULE4
      dec_next.literal  = fetch_word[7:0];
      dec_next.file_addr = {10'h000, first_reg[5:4]};
      if (kind_first == iod_pkg::IOD_K_IDX_MOVE)
      begin
        dec_next.src_addr = src_base + {5'h00, first_reg[6:0]};  // see RULE5, RULE19
        dec_next.dst_addr = dst_base + {5'h00, fetch_word[6:0]}; // see RULE5, RULE19
      end
    end
  end

  // ----------------------------------------------------------------------
  // Result register
  // ----------------------------------------------------------------------

  // Results stand until the next instruction completes.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      dec       <= '0;
      dec_valid <= 1'b0;
    end
    else
    begin
      dec_valid <= take && !(take1 && two_word);
      if (take && !(take1 && two_word))
        dec <= dec_next;
    end
  end

  // ----------------------------------------------------------------------
  // Table pointer
  // ----------------------------------------------------------------------

  // A table access updates the pointer; it outranks a load in the same cycle.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      tp_reg <= `IOD_TP_RESET;
    else if (take1 && (kind_now == iod_pkg::IOD_K_TBL))
    begin
      case (fetch_word[1:0]) // see RULE1, RULE2
        `IOD_TBL_POST_INC: tp_reg <= tp_reg + 21'h000001;
        `IOD_TBL_POST_DEC: tp_reg <= tp_reg - 21'h000001;
        `IOD_TBL_PRE_INC:  tp_reg <= tp_reg + 21'h000001;
        default:           tp_reg <= tp_reg;
      endcase
    end
    else if (tp_load)
      tp_reg <= tp_load_val;
  end

  assign table_pointer = tp_reg;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  property p_phase;
    word_ready |=> !word_ready [*3] ##1 word_ready;
  endproperty
  a_phase: assert property (p_phase) else $error("Cycle is not four clocks."); // see RULE17

  property p_byte;
    take1 && fetch_word[15:12] == 4'h2
      |=> dec_valid && dec.kind == iod_pkg::IOD_K_BYTE && dec.dest_to_file == $past(fetch_word[9])
          && dec.use_bank == $past(fetch_word[8]) && dec.file_addr[7:0] == $past(fetch_word[7:0]);
  endproperty
  a_byte: assert property (p_byte) else $error("Byte operands wrong."); // see RULE7

  property p_bit;
    take1 && fetch_word[15:14] == 2'h2
      |=> dec.kind == iod_pkg::IOD_K_BIT && dec.bit_sel == $past(fetch_word[11:9])
          && dec.use_bank == $past(fetch_word[8]);
  endproperty
  a_bit: assert property (p_bit) else $error("Bit operands wrong."); // see RULE11

  property p_lit;
    take1 && fetch_word[15:8] == 8'h0E |=> dec.kind == iod_pkg::IOD_K_LIT && dec.literal == $past(fetch_word[7:0]);
  endproperty
  a_lit: assert property (p_lit) else $error("Literal wrong."); // see RULE12

  property p_rel_branch;
    take1 && fetch_word[15:11] == 5'h1A |=> dec.target == $past(next_pc) + {{9{$past(fetch_word[10])}}, $past(fetch_word[10:0]), 1'b0};
  endproperty
  a_rel_branch: assert property (p_rel_branch) else $error("Branch target wrong."); // see RULE14

  property p_lone;
    take1 && fetch_word[15:12] == 4'hF |=> dec_valid && dec.kind == iod_pkg::IOD_K_NOP;
  endproperty
  a_lone: assert property (p_lone) else $error("Lone second word not NOP."); // see RULE16

  property p_tbl;
    take1 && fetch_word[15:2] == 14'h0002 && fetch_word[1:0] == 2'h1 |=> tp_reg == $past(tp_reg) + 21'h000001;
  endproperty
  a_tbl: assert property (p_tbl) else $error("Post-increment wrong."); // see RULE1

  property p_jump;
    take1 && fetch_word[15:8] == 8'hEF ##4 take && second_ok
      |=> dec_valid && dec.kind == iod_pkg::IOD_K_JUMP && dec.target[8:1] == $past(first_reg[7:0]);
  endproperty
  a_jump: assert property (p_jump) else $error("Jump target wrong."); // see RULE13

  property p_flush;
    take1 && fetch_word[15:11] == 5'h1A ##4 take |=> dec.kind == iod_pkg::IOD_K_NOP;
  endproperty
  a_flush: assert property (p_flush) else $error("No NOP after branch."); // see RULE17

  property p_cond_branch;
    take1 && fetch_word[15:11] == 5'h1C
      |=> dec.target == $past(next_pc) + {{12{$past(fetch_word[7])}}, $past(fetch_word[7:0]), 1'b0};
  endproperty
  a_cond_branch: assert property (p_cond_branch) else $error("Conditional target wrong."); // see RULE15

  property p_pre_inc;
    take1 && fetch_word[15:3] == 13'h0001 && fetch_word[1:0] == 2'h3
      |=> dec.tbl_addr == $past(tp_reg) + 21'h000001 && tp_reg == $past(tp_reg) + 21'h000001;
  endproperty
  a_pre_inc: assert property (p_pre_inc) else $error("Pre-increment wrong."); // see RULE1

  property p_move;
    take && state_reg == iod_pkg::IOD_S_SECOND && second_ok && kind_first == iod_pkg::IOD_K_MOVE
      |=> dec_valid && dec.src_addr == $past(first_reg[11:0]) && dec.dst_addr == $past(fetch_word[11:0]);
  endproperty
  a_move: assert property (p_move) else $error("Move addresses wrong."); // see RULE10

  property p_skip;
    discard_next |=> flush_reg;
  endproperty
  a_skip: assert property (p_skip) else $error("Skip request lost."); // see RULE17

endmodule : iod_decoder

// [inc/iod_map.svh]
// Encodings, field positions and cycle counts of the operand decoder.
`ifndef IOD_MAP_SVH
`define IOD_MAP_SVH

// ----------------------------------------------------------------------
// Instruction cycle timing
// ----------------------------------------------------------------------
`define IOD_OSC_PER_CYCLE 3'h4
`define IOD_Q_LAST        2'h3

// ----------------------------------------------------------------------
// Word fields
// ----------------------------------------------------------------------
`define IOD_SECOND_TAG    4'hF
`define IOD_DEST_BIT      9
`define IOD_BANK_BIT      8
`define IOD_FAST_BIT      0
`define IOD_CALL_FAST_BIT 8
`define IOD_TBL_WR_BIT    2

// ----------------------------------------------------------------------
// Table pointer handling modes
// ----------------------------------------------------------------------
`define IOD_TBL_KEEP      2'h0
`define IOD_TBL_POST_INC  2'h1
`define IOD_TBL_POST_DEC  2'h2
`define IOD_TBL_PRE_INC   2'h3

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define IOD_TP_RESET      21'h000000

`endif

// [inc/iod_pkg.sv]
// Types shared by the instruction operand decoder.
package iod_pkg;

  // ----------------------------------------------------------------------
  // Instruction classes
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    IOD_K_NOP      = 4'h0,
    IOD_K_BYTE     = 4'h1,
    IOD_K_BIT      = 4'h2,
    IOD_K_LIT      = 4'h3,
    IOD_K_MOVE     = 4'h4,
    IOD_K_JUMP     = 4'h5,
    IOD_K_CALL     = 4'h6,
    IOD_K_RET      = 4'h7,
    IOD_K_REL_JMP  = 4'h8,
    IOD_K_RCALL    = 4'h9,
    IOD_K_BCOND    = 4'hA,
    IOD_K_TBL      = 4'hB,
    IOD_K_IDX_MOVE = 4'hC,
    IOD_K_LFSR     = 4'hD,
    IOD_K_OTHER    = 4'hE
  } iod_kind_e;

  typedef enum logic [0:0] {
    IOD_S_FIRST  = 1'b0,
    IOD_S_SECOND = 1'b1
  } iod_state_e;

  // ----------------------------------------------------------------------
  // Decoded operands of one instruction
  // ----------------------------------------------------------------------
  typedef struct packed {
    iod_kind_e   kind;
    logic        dest_to_file;
    logic        use_bank;
    logic        fast;
    logic        tbl_write;
    logic [1:0]  tbl_mode;
    logic [2:0]  bit_sel;
    logic [7:0]  literal;
    logic [11:0] file_addr;
    logic [11:0] src_addr;
    logic [11:0] dst_addr;
    logic [20:0] target;
    logic [20:0] tbl_addr;
  } iod_dec_s;

endpackage : iod_pkg
